// *** verilog/ppfm_defs.vh ***
`ifndef PPFM_DEFS_VH
`define PPFM_DEFS_VH

// apb address width and register byte offsets
`define PPFM_ADDR_W 8
`define PPFM_OFF_DATA 8'h00
`define PPFM_OFF_DIR 8'h04
`define PPFM_OFF_MODE 8'h08
`define PPFM_OFF_FSEL 8'h0C
`define PPFM_OFF_ODR 8'h10
`define PPFM_OFF_BITOP 8'h14
`define PPFM_OFF_EDGE 8'h18
`define PPFM_OFF_DBG 8'h1C
`define PPFM_OFF_IRQ_STAT 8'h20
`define PPFM_OFF_IRQ_MASK 8'h24
`define PPFM_OFF_PIN_LEVEL 8'h28

// reset values
`define PPFM_RST_DIR 8'hFF
`define PPFM_RST_ZERO 8'h00
`define PPFM_RST_EDGE 2'h0
`define PPFM_RST_IRQ 2'h0
`define PPFM_RST_DBG_EN 1'h1
`define PPFM_RST_DBG_MODE 1'h0

// single-bit operation word layout
`define PPFM_BITOP_IDX_RANGE 2:0
`define PPFM_BITOP_OP_RANGE 9:8
`define PPFM_OP_KEEP 2'h0
`define PPFM_OP_SET 2'h1
`define PPFM_OP_CLR 2'h2
`define PPFM_OP_INV 2'h3

// edge select for the interrupt-shared pin
`define PPFM_EDGE_RANGE 1:0
`define PPFM_EDGE_NONE 2'h0
`define PPFM_EDGE_RISE 2'h1
`define PPFM_EDGE_FALL 2'h2
`define PPFM_EDGE_BOTH 2'h3

// debug control register bits
`define PPFM_DBG_EN_BIT 0
`define PPFM_DBG_ACT_BIT 1

// interrupt status / mask layout
`define PPFM_IRQ_W 2
`define PPFM_IRQ_NMI 0
`define PPFM_IRQ_DBG 1

`endif

// *** verilog/ppfm_pin_cell.v ***
module ppfm_pin_cell (
	input wire latch_in,
	input wire dir_in,
	input wire mode_in,
	input wire fsel_in,
	input wire od_in,
	input wire pin_in,
	input wire hold_input_in,
	input wire alt1_data_in,
	input wire alt1_drive_in,
	input wire alt2_data_in,
	input wire alt2_drive_in,
	output reg pin_val_out,
	output reg pin_oen_out,
	output reg alt_in_out,
	output reg rd_out
);

	reg drive;
	reg val;
	reg od_eff;

	// per-pin function decode and buffer control
	always @*
	begin
		drive = 1'h0;
		val = 1'h0;
		od_eff = 1'h0;
		rd_out = dir_in ? pin_in : latch_in;
		alt_in_out = mode_in & pin_in;
		if (hold_input_in)
		begin
			drive = 1'h0;
		end
		else if (!mode_in)
		begin
			drive = ~dir_in;
			val = latch_in;
			od_eff = od_in & ~dir_in;
		end
		else if (!fsel_in)
		begin
			drive = alt1_drive_in;
			val = alt1_data_in;
			od_eff = od_in;
		end
		else
		begin
			drive = alt2_drive_in;
			val = alt2_data_in;
			od_eff = od_in;
		end
		// open drain only pulls low
		if (od_eff)
		begin
			pin_val_out = 1'h0;
			pin_oen_out = ~(drive & ~val);
		end
		else
		begin
			pin_val_out = val;
			pin_oen_out = ~drive;
		end
	end

endmodule // ppfm_pin_cell

// *** verilog/ppfm_top.v ***
// Overview of operation
// - data read gives latch for direction 0, pin level for direction 1
// - any data write updates the output latch in every mode
// - mode 0 port, mode 1 select 0 first alt, select 1 second alt
// - in port mode open-drain acts only when direction is output
// - alternate-function input is mode bit AND pin level
// - pin high, rising edge chosen: mode 0 to 1 raises interrupt
// - pin high, falling edge chosen: mode 1 to 0 raises interrupt
// - single-bit operation reads eight bits, modifies one, writes eight back
// - after pin reset shared pin is debug reset; high enters debug mode
// - watchdog, clock monitor, low-voltage resets leave debug pin and control alone
// - pull-down on after pin reset, off once debug enable is cleared
//
// The APB register port and the placing of the registers were decided locally.
`include "ppfm_defs.vh"

module ppfm_top #(
	parameter W = 8,
	parameter NMI_PIN = 2,
	parameter DBG_PIN = 5
) (
	input wire CLK_IN,
	input wire RESETN_IN,
	input wire WDT_RESET_IN,
	input wire CLKMON_RESET_IN,
	input wire LVD_RESET_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [`PPFM_ADDR_W-1:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output wire [31:0] PRDATA_OUT,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	input wire [W-1:0] PIN_IN,
	output wire [W-1:0] PIN_OUT,
	output wire [W-1:0] PIN_OEN_OUT,
	input wire [W-1:0] ALT1_DATA_IN,
	input wire [W-1:0] ALT1_DRIVE_IN,
	input wire [W-1:0] ALT2_DATA_IN,
	input wire [W-1:0] ALT2_DRIVE_IN,
	output wire [W-1:0] ALT_INPUT_OUT,
	output wire NMI_OUT,
	output wire DEBUG_MODE_OUT,
	output wire DEBUG_IF_EN_OUT,
	output wire PULLDOWN_EN_OUT,
	output wire IRQ_OUT
);

	// port control state
	reg [W-1:0] latch;
	reg [W-1:0] dir;
	reg [W-1:0] mode;
	reg [W-1:0] fsel;
	reg [W-1:0] odr;
	reg [1:0] edge_sel;
	reg [`PPFM_IRQ_W-1:0] irq_stat;
	reg [`PPFM_IRQ_W-1:0] irq_mask;
	// debug control state, pin reset only
	reg dbg_en;
	reg dbg_mode;
	// pin synchroniser and registered outputs
	reg [W-1:0] pin_meta;
	reg [W-1:0] pin_sync;
	reg [W-1:0] alt_in_q;
	reg gate_prev;
	reg nmi_q;
	reg [W-1:0] pin_out_q;
	reg [W-1:0] pin_oen_q;
	reg [31:0] prdata;

	reg [W-1:0] next_latch;
	reg [`PPFM_IRQ_W-1:0] next_irq_stat;
	reg [31:0] rd_mux;
	reg mapped;

	wire [W-1:0] rd_view;
	wire [W-1:0] cell_val;
	wire [W-1:0] cell_oen;
	wire [W-1:0] cell_alt_in;
	wire [W-1:0] hold_input;
	wire port_rst;
	wire setup;
	wire wr;
	wire [1:0] bit_op;
	wire [2:0] bit_idx;
	wire gate_now;
	wire nmi_event;
	wire dbg_event;
	wire [`PPFM_IRQ_W-1:0] events;

	// internal resets clear port state only
	assign port_rst = ~RESETN_IN | WDT_RESET_IN | CLKMON_RESET_IN | LVD_RESET_IN;

	// apb decode, zero wait states
	assign setup = PSEL_IN & ~PENABLE_IN;
	assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign PREADY_OUT = 1'h1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
	assign PRDATA_OUT = prdata;
	assign bit_op = PWDATA_IN[`PPFM_BITOP_OP_RANGE];
	assign bit_idx = PWDATA_IN[`PPFM_BITOP_IDX_RANGE];

	// shared debug pin stays an input while debug enable is set
	genvar gi;
	generate
		for (gi = 0; gi < W; gi = gi + 1)
		begin : g_pin
			assign hold_input[gi] = (gi == DBG_PIN) ? dbg_en : 1'h0;
			ppfm_pin_cell u_cell (
				.latch_in(latch[gi]),
				.dir_in(dir[gi]),
				.mode_in(mode[gi]),
				.fsel_in(fsel[gi]),
				.od_in(odr[gi]),
				.pin_in(pin_sync[gi]),
				.hold_input_in(hold_input[gi]),
				.alt1_data_in(ALT1_DATA_IN[gi]),
				.alt1_drive_in(ALT1_DRIVE_IN[gi]),
				.alt2_data_in(ALT2_DATA_IN[gi]),
				.alt2_drive_in(ALT2_DRIVE_IN[gi]),
				.pin_val_out(cell_val[gi]),
				.pin_oen_out(cell_oen[gi]),
				.alt_in_out(cell_alt_in[gi]),
				.rd_out(rd_view[gi])
			);
		end
	endgenerate

	// register address decode and read mux
	always @*
	begin
		mapped = 1'h1;
		rd_mux = 32'h0;
		case (PADDR_IN)
			`PPFM_OFF_DATA: rd_mux[W-1:0] = rd_view;
			`PPFM_OFF_DIR: rd_mux[W-1:0] = dir;
			`PPFM_OFF_MODE: rd_mux[W-1:0] = mode;
			`PPFM_OFF_FSEL: rd_mux[W-1:0] = fsel;
			`PPFM_OFF_ODR: rd_mux[W-1:0] = odr;
			`PPFM_OFF_BITOP: rd_mux = 32'h0;
			`PPFM_OFF_EDGE: rd_mux[`PPFM_EDGE_RANGE] = edge_sel;
			`PPFM_OFF_DBG:
			begin
				rd_mux[`PPFM_DBG_EN_BIT] = dbg_en;
				rd_mux[`PPFM_DBG_ACT_BIT] = dbg_mode;
			end
			`PPFM_OFF_IRQ_STAT: rd_mux[`PPFM_IRQ_W-1:0] = irq_stat;
			`PPFM_OFF_IRQ_MASK: rd_mux[`PPFM_IRQ_W-1:0] = irq_mask;
			`PPFM_OFF_PIN_LEVEL: rd_mux[W-1:0] = pin_sync;
			default: mapped = 1'h0;
		endcase
	end

	// output latch update
	always @*
	begin
		next_latch = latch;
		if (wr && PADDR_IN == `PPFM_OFF_DATA)
		begin
			next_latch = PWDATA_IN[W-1:0];
		end
		else if (wr && PADDR_IN == `PPFM_OFF_BITOP)
		begin
			// read all, modify one, write all
			next_latch = rd_view;
			case (bit_op)
				`PPFM_OP_SET: next_latch[bit_idx] = 1'h1;
				`PPFM_OP_CLR: next_latch[bit_idx] = 1'h0;
				`PPFM_OP_INV: next_latch[bit_idx] = ~rd_view[bit_idx];
				default: next_latch[bit_idx] = rd_view[bit_idx];
			endcase
		end
	end

	// edge detect on the gated interrupt input
	assign gate_now = alt_in_q[NMI_PIN];
	assign nmi_event = ((edge_sel == `PPFM_EDGE_RISE || edge_sel == `PPFM_EDGE_BOTH) & gate_now & ~gate_prev) |
		((edge_sel == `PPFM_EDGE_FALL || edge_sel == `PPFM_EDGE_BOTH) & ~gate_now & gate_prev);
	// high on debug reset input enters debug
	assign dbg_event = dbg_en & pin_sync[DBG_PIN] & ~dbg_mode;

	assign events[`PPFM_IRQ_NMI] = nmi_event;
	assign events[`PPFM_IRQ_DBG] = dbg_event;

	// sticky status, set beats write-one clear
	always @*
	begin
		next_irq_stat = irq_stat;
		if (wr && PADDR_IN == `PPFM_OFF_IRQ_STAT)
			next_irq_stat = irq_stat & ~PWDATA_IN[`PPFM_IRQ_W-1:0];
		next_irq_stat = next_irq_stat | events;
	end

	// pin synchroniser, two stages
	always @(posedge CLK_IN)
	begin
		pin_meta <= PIN_IN;
		pin_sync <= pin_meta;
	end

	// port configuration registers
	always @(posedge CLK_IN)
	begin
		if (port_rst)
		begin
			latch <= `PPFM_RST_ZERO;
			dir <= `PPFM_RST_DIR;
			mode <= `PPFM_RST_ZERO;
			fsel <= `PPFM_RST_ZERO;
			odr <= `PPFM_RST_ZERO;
			edge_sel <= `PPFM_RST_EDGE;
			irq_stat <= `PPFM_RST_IRQ;
			irq_mask <= `PPFM_RST_IRQ;
		end
		else
		begin
			latch <= next_latch;
			irq_stat <= next_irq_stat;
			if (wr && PADDR_IN == `PPFM_OFF_DIR)
				dir <= PWDATA_IN[W-1:0];
			if (wr && PADDR_IN == `PPFM_OFF_MODE)
				mode <= PWDATA_IN[W-1:0];
			if (wr && PADDR_IN == `PPFM_OFF_FSEL)
				fsel <= PWDATA_IN[W-1:0];
			if (wr && PADDR_IN == `PPFM_OFF_ODR)
				odr <= PWDATA_IN[W-1:0];
			if (wr && PADDR_IN == `PPFM_OFF_EDGE)
				edge_sel <= PWDATA_IN[`PPFM_EDGE_RANGE];
			if (wr && PADDR_IN == `PPFM_OFF_IRQ_MASK)
				irq_mask <= PWDATA_IN[`PPFM_IRQ_W-1:0];
		end
	end

	// debug control, only the pin reset touches it
	always @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			dbg_en <= `PPFM_RST_DBG_EN;
			dbg_mode <= `PPFM_RST_DBG_MODE;
		end
		else
		begin
			if (dbg_event)
				dbg_mode <= 1'h1;
			if (wr && PADDR_IN == `PPFM_OFF_DBG)
				dbg_en <= PWDATA_IN[`PPFM_DBG_EN_BIT];
		end
	end

	// gated inputs, edge history and pin buffers
	always @(posedge CLK_IN)
	begin
		if (port_rst)
		begin
			alt_in_q <= `PPFM_RST_ZERO;
			gate_prev <= 1'h0;
			nmi_q <= 1'h0;
			pin_out_q <= `PPFM_RST_ZERO;
			pin_oen_q <= `PPFM_RST_DIR;
		end
		else
		begin
			alt_in_q <= cell_alt_in;
			gate_prev <= gate_now;
			nmi_q <= nmi_event;
			pin_out_q <= cell_val;
			pin_oen_q <= cell_oen;
		end
	end

	// read data captured in setup phase
	always @(posedge CLK_IN)
	begin
		if (port_rst)
			prdata <= 32'h0;
		else if (setup && !PWRITE_IN)
			prdata <= rd_mux;
	end

	assign PIN_OUT = pin_out_q;
	assign PIN_OEN_OUT = pin_oen_q;
	assign ALT_INPUT_OUT = alt_in_q;
	assign NMI_OUT = nmi_q;
	assign DEBUG_MODE_OUT = dbg_mode;
	assign DEBUG_IF_EN_OUT = dbg_mode;
	assign PULLDOWN_EN_OUT = dbg_en;
	// level interrupt from unmasked status
	assign IRQ_OUT = |(irq_stat & irq_mask);

endmodule // ppfm_top

// *** sim/ppfm_asserts.sv ***
module ppfm_asserts #(
	parameter W = 8
) (
	input wire CLK_IN,
	input wire RESETN_IN,
	input wire WDT_RESET_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [7:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [W-1:0] PIN_IN,
	input wire [W-1:0] PIN_OEN_OUT,
	input wire [W-1:0] ALT_INPUT_OUT,
	input wire NMI_OUT,
	input wire DEBUG_MODE_OUT,
	input wire DEBUG_IF_EN_OUT,
	input wire PULLDOWN_EN_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	// interrupt pulse lasts one cycle
	sequence s_pulse;
		NMI_OUT ##1 !NMI_OUT;
	endsequence
	// gated interrupt input changed one cycle back
	sequence s_flip;
		$past(ALT_INPUT_OUT[2]) != $past(ALT_INPUT_OUT[2], 2);
	endsequence
	a_alt_gated: assert property ((ALT_INPUT_OUT & ~$past(PIN_IN, 3)) == 0)
		else $error("gated input high on low pin");
	a_nmi_pulse: assert property (NMI_OUT |-> s_pulse)
		else $error("interrupt pulse too long");
	a_nmi_cause: assert property (NMI_OUT |-> s_flip)
		else $error("interrupt without input edge");
	a_dbg_if: assert property (DEBUG_IF_EN_OUT == DEBUG_MODE_OUT)
		else $error("debug pins not following mode");
	a_dbg_entry: assert property ($rose(DEBUG_MODE_OUT) |-> $past(PULLDOWN_EN_OUT) && $past(PIN_IN[5], 3))
		else $error("debug entry without pin");
	a_dbg_kept: assert property (WDT_RESET_IN && !PSEL_IN |=> !$fell(DEBUG_MODE_OUT) && $stable(PULLDOWN_EN_OUT))
		else $error("watchdog touched debug");
	a_pd_release: assert property ($fell(PULLDOWN_EN_OUT) |->
		$past(PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 8'h1C && !PWDATA_IN[0]))
		else $error("pull-down dropped without write");
	a_reset_idle: assert property ($rose(RESETN_IN) |->
		PIN_OEN_OUT == 8'hFF && ALT_INPUT_OUT == 8'h00 && PULLDOWN_EN_OUT)
		else $error("bad state after reset");
endmodule // ppfm_asserts

bind ppfm_top ppfm_asserts #(.W(W)) ppfm_asserts_inst (.CLK_IN, .RESETN_IN, .WDT_RESET_IN, .PSEL_IN,
	.PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PIN_IN, .PIN_OEN_OUT, .ALT_INPUT_OUT, .NMI_OUT,
	.DEBUG_MODE_OUT, .DEBUG_IF_EN_OUT, .PULLDOWN_EN_OUT);

// *** sim/ppfm_pins.sv ***
module ppfm_pins (
	input wire [7:0] pin_out_in,
	input wire [7:0] pin_oen_in,
	input wire [7:0] ext_in,
	output wire [7:0] pin_lvl_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// driven bits follow the device, released bits the outside pull
	assign pin_lvl_out = (pin_out_in & ~pin_oen_in) | (ext_in & pin_oen_in);
endmodule // ppfm_pins

// *** sim/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rstn = 0, wdt = 0, psel = 0, pen = 0, pwr = 0, e, rdy, err, nmi, dbgm, dbgi, pd, irq;
	logic cmr = 0, lvr = 0;
	logic [7:0] pa = 0, ext = 0, a1 = 0, a2 = 0, dr = 0, pin, pout, poen, alt, d, m, v, k;
	logic [31:0] pwd = 0, prd, r;
	logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
	logic [31:0] rv [5] = '{32'hFF, 32'h0, 32'h0, 32'h0, 32'h1};
	int bad_count = 0, num_checks = 0, cyc = 0, nmis = 0;
	ppfm_top ppfm_top_inst (.CLK_IN(clk), .RESETN_IN(rstn), .WDT_RESET_IN(wdt), .CLKMON_RESET_IN(cmr),
		.LVD_RESET_IN(lvr), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
		.PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OEN_OUT(poen),
		.ALT1_DATA_IN(a1), .ALT1_DRIVE_IN(dr), .ALT2_DATA_IN(a2), .ALT2_DRIVE_IN(dr), .ALT_INPUT_OUT(alt),
		.NMI_OUT(nmi), .DEBUG_MODE_OUT(dbgm), .DEBUG_IF_EN_OUT(dbgi), .PULLDOWN_EN_OUT(pd), .IRQ_OUT(irq));
	ppfm_pins ppfm_pins_inst (.pin_out_in(pout), .pin_oen_in(poen), .ext_in(ext), .pin_lvl_out(pin));
	// 250 MHz clock
	initial forever #2 clk = ~clk;
	// cycle limit and interrupt pulse count
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		nmis <= nmis + nmi;
		if (cyc == 4000)
		begin
			bad_count++;
			finish_test;
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= dt;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		r = prd;
		e = err;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task rst;
		rstn <= 0;
		repeat (12) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
	endtask
	task finish_test;
		$display("checks %0d bad %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function logic [7:0] bit_op(input logic [7:0] x, input logic [1:0] o, input logic [2:0] b);
		case (o)
			2'h1: return x | (8'h01 << b);
			2'h2: return x & ~(8'h01 << b);
			2'h3: return x ^ (8'h01 << b);
			default: return x;
		endcase
	endfunction
	// main sequence
	initial
	begin
		void'($urandom(92));
		rst;
		foreach (ra[i])
		begin
			apb(0, ra[i], 32'h0);
			chk(r, rv[i]);
		end
		chk(pd, 1'h1);
		apb(1, 8'h08, 32'h1);
		ext <= 8'h20;
		repeat (5) @(posedge clk);
		chk({dbgm, dbgi}, 2'h3);
		// watchdog, clock monitor and low-voltage resets in turn
		for (int j = 0; j < 3; j++)
		begin
			{wdt, cmr, lvr} <= 3'h4 >> j;
			@(posedge clk);
			{wdt, cmr, lvr} <= 3'h0;
			@(posedge clk);
			chk({dbgm, pd}, 2'h3);
		end
		apb(0, 8'h08, 32'h0);
		chk(r, 32'h0);
		ext <= 8'h00;
		rst;
		apb(1, 8'h1C, 32'h0);
		chk({dbgm, pd}, 2'h0);
		$display("test debug done");
		for (int i = 0; i < 4; i++)
		begin
			d = $urandom;
			m = $urandom;
			k = $urandom;
			ext <= k;
			apb(1, 8'h04, {24'h0, m});
			apb(1, 8'h00, {24'h0, d});
			apb(0, 8'h00, 32'h0);
			v = (d & ~m) | (k & m);
			chk(r, v);
			apb(1, 8'h14, {22'h0, i[1:0], 5'h0, k[2:0]});
			apb(1, 8'h04, 32'h0);
			apb(0, 8'h00, 32'h0);
			v = bit_op(v, i[1:0], k[2:0]);
			chk(r, v);
			@(posedge clk);
			chk(pout, v);
		end
		$display("test data done");
		apb(1, 8'h04, 32'hFF);
		apb(1, 8'h10, 32'hFF);
		apb(1, 8'h00, 32'hA5);
		chk(poen, 8'hFF);
		apb(1, 8'h04, 32'h0);
		@(posedge clk);
		chk({pout, poen}, 16'h00A5);
		a1 <= $urandom;
		a2 <= $urandom;
		apb(1, 8'h10, 32'h0);
		apb(1, 8'h0C, 32'hF0);
		apb(1, 8'h08, 32'hFF);
		dr <= 8'hFF;
		repeat (2) @(posedge clk);
		chk({pout, poen}, {a2 & 8'hF0 | a1 & 8'h0F, 8'h00});
		dr <= 8'h00;
		ext <= $urandom;
		apb(1, 8'h08, 32'h0F);
		repeat (3) @(posedge clk);
		chk(alt, ext & 8'h0F);
		$display("test pins done");
		ext <= 8'h04;
		apb(1, 8'h08, 32'h0);
		apb(1, 8'h18, 32'h1);
		apb(1, 8'h24, 32'h1);
		apb(1, 8'h08, 32'h04);
		repeat (3) @(posedge clk);
		chk(nmis, 32'h1);
		chk(irq, 1'h1);
		apb(1, 8'h24, 32'h0);
		chk(irq, 1'h0);
		apb(1, 8'h20, 32'h1);
		apb(0, 8'h20, 32'h0);
		chk(r, 32'h0);
		apb(1, 8'h18, 32'h2);
		apb(1, 8'h08, 32'h0);
		repeat (3) @(posedge clk);
		chk(nmis, 32'h2);
		apb(0, 8'h20, 32'h0);
		chk(r, 32'h1);
		// safe switching: edge chosen after alt mode, cleared before port mode
		apb(1, 8'h08, 32'h04);
		apb(1, 8'h18, 32'h1);
		apb(1, 8'h18, 32'h0);
		apb(1, 8'h08, 32'h0);
		repeat (3) @(posedge clk);
		chk(nmis, 32'h2);
		// both edges: mode up and down give one pulse each
		apb(1, 8'h18, 32'h3);
		apb(1, 8'h08, 32'h04);
		apb(1, 8'h08, 32'h0);
		repeat (3) @(posedge clk);
		chk(nmis, 32'h4);
		apb(0, 8'h3C, 32'h0);
		chk(e, 1'h1);
		chk(r, 32'h0);
		$display("test interrupt done");
		finish_test;
	end
endmodule // tb_top
